// [rtl/pipe_params.svh]
// Purpose: constants of the four-phase pipeline: field positions, reset values.
// Assumes: 16-bit instruction words, one fetch per cycle.
// Notes: the types live in pipe_pkg.
// How it works
// - each unstalled fetch takes the next program word and bumps the counter.
// - indirect pointer post-modification happens in the decode phase.
// - operand read uses the pointer value from before the decode update.
// - mapped accumulator store to a pointer lands in execute; same-cycle decode collides.
// - a two-word instruction has its second word fetched in the next slot.
// - the decode slot holding a second word is a dummy through all phases.
// - immediate pointer load does no decode arithmetic, writes pointer in execute.
// - immediate accumulator load skips operand read, loads accumulator in execute.
// - mapped store reads no data, no decode arithmetic, writes only in execute.
// - memory accumulator load takes the word read one cycle earlier.
// - add sums the prior-cycle operand with the accumulator, writes it back.
// - no-operation passes as dummies and changes no state.
`ifndef PIPE_PARAMS_SVH
`define PIPE_PARAMS_SVH

`define OP_MSB 15
`define OP_LSB 12
`define ARP_LOAD_BIT 6
`define ARP_MSB 9
`define ARP_LSB 7
`define MOD_MSB 5
`define MOD_LSB 4
`define TGT_MSB 3
`define TGT_LSB 0
`define TGT_INDEX 4'h8
`define PC_RESET 16'h0000
`define ARP_RESET 3'h0
`define WORD_RESET 16'h0000

`endif

// [rtl/pipe_pkg.sv]
// Purpose: types shared by the pipeline.
// Assumes: opcode sits in the top nibble of the instruction word.
// Notes: unknown opcodes decode as no-operation.
package pipe_pkg;
    typedef enum logic [3:0] {
        OP_NOP = 4'h0,
        OP_LDACC_IMM = 4'h1,
        OP_LDACC_IND = 4'h2,
        OP_ADD_IND = 4'h3,
        OP_LDPTR_IMM = 4'h4,
        OP_STORE_MAPPED = 4'h5
    } opcode_e;
    typedef enum logic [1:0] {
        MOD_NONE = 2'h0,
        MOD_INC = 2'h1,
        MOD_DEC = 2'h2,
        MOD_INDEX = 2'h3
    } ptr_mod_e;
endpackage

// [rtl/four_stage_pipeline.sv]
// Purpose: fetch, decode, operand read and execute phases with pointer updates.
// Assumes: program and data memories answer combinationally to the registered
//          addresses this block drives; fetchStall comes from same-clock logic.
// Notes: a stall during a pending second word is not supported.
`timescale 1ns/10ps
`include "pipe_params.svh"

module four_stage_pipeline #(
    parameter int DW = 16,
    parameter int NPTR = 8
) (
    input wire logic sys_clk, // core clock
    input wire logic rst_n, // async reset, active low
    input wire logic fetchStall, // hold fetch this cycle
    input wire logic [15:0] progData, // word at progAddr
    output logic [15:0] progAddr, // program counter
    input wire logic [DW-1:0] dataRdData, // word at dataRdAddr
    output logic [DW-1:0] dataRdAddr, // operand read address
    output logic dataRdEn, // operand read active
    output logic [DW-1:0] accumulatorReg, // accumulator
    output logic [DW-1:0] auxPointerTwo, // pointer two
    output logic ptrCollision // execute write met decode update
);
    localparam int SW = $clog2(NPTR);

    logic [15:0] pc_r;
    logic [15:0] decWord_r;
    logic decValid_r;
    logic decSecond_r;
    pipe_pkg::opcode_e rdOp_r;
    logic [3:0] rdTgt_r;
    pipe_pkg::opcode_e exOp_r;
    logic [3:0] exTgt_r;
    logic [DW-1:0] exImm_r;
    logic [DW-1:0] exOperand_r;
    logic [DW-1:0] acc_r;
    logic [DW-1:0] index_r;
    logic [SW-1:0] arp_r;
    logic [DW-1:0] arFile_r [NPTR];
    logic [DW-1:0] dataRdAddr_r;
    logic dataRdEn_r;
    logic collision_r;

    pipe_pkg::opcode_e decOp;
    logic decIndirect;
    logic decTwoWord;
    pipe_pkg::ptr_mod_e decMod;
    logic [DW-1:0] curPtr;
    logic [DW-1:0] ptr_nxt;
    logic exPtrWrite;
    logic [SW-1:0] exPtrIdx;
    logic [DW-1:0] exPtrVal;

    // map the opcode field, unknown codes become no-operation
    function automatic pipe_pkg::opcode_e mapOp(input logic [15:0] w);
        pipe_pkg::opcode_e o;
        o = pipe_pkg::OP_NOP;
        case (w[`OP_MSB:`OP_LSB])
            4'h1: o = pipe_pkg::OP_LDACC_IMM;
            4'h2: o = pipe_pkg::OP_LDACC_IND;
            4'h3: o = pipe_pkg::OP_ADD_IND;
            4'h4: o = pipe_pkg::OP_LDPTR_IMM;
            4'h5: o = pipe_pkg::OP_STORE_MAPPED;
            default: o = pipe_pkg::OP_NOP;
        endcase
        return o;
    endfunction

    // decode phase: opcode, addressing and post-modified pointer
    always_comb begin
        decOp = pipe_pkg::OP_NOP;
        if (decValid_r && !decSecond_r) begin
            decOp = mapOp(decWord_r);
        end
        // only indirect ops touch the pointer unit
        decIndirect = (decOp == pipe_pkg::OP_LDACC_IND) || (decOp == pipe_pkg::OP_ADD_IND);
        decTwoWord = (decOp == pipe_pkg::OP_LDACC_IMM) || (decOp == pipe_pkg::OP_LDPTR_IMM);
        decMod = pipe_pkg::ptr_mod_e'(decWord_r[`MOD_MSB:`MOD_LSB]);
        curPtr = arFile_r[arp_r];
        case (decMod)
            pipe_pkg::MOD_INC: ptr_nxt = curPtr + {{(DW-1){1'b0}}, 1'b1};
            pipe_pkg::MOD_DEC: ptr_nxt = curPtr - {{(DW-1){1'b0}}, 1'b1};
            pipe_pkg::MOD_INDEX: ptr_nxt = curPtr + index_r;
            default: ptr_nxt = curPtr;
        endcase
    end

    // execute-phase pointer write from mapped store or immediate load
    always_comb begin
        exPtrWrite = 1'b0;
        exPtrVal = acc_r;
        exPtrIdx = exTgt_r[SW-1:0];
        if (exOp_r == pipe_pkg::OP_STORE_MAPPED && exTgt_r < 4'(NPTR)) begin
            exPtrWrite = 1'b1;
        end
        if (exOp_r == pipe_pkg::OP_LDPTR_IMM && exTgt_r < 4'(NPTR)) begin
            exPtrWrite = 1'b1;
            exPtrVal = exImm_r;
        end
    end

    // fetch phase: program counter
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_r <= `PC_RESET;
        end else if (!fetchStall) begin
            pc_r <= pc_r + 16'h0001;
        end
    end

    // fetch to decode slot; a stall inserts a dummy
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            decWord_r <= `WORD_RESET;
            decValid_r <= 1'b0;
            decSecond_r <= 1'b0;
        end else if (fetchStall) begin
            decValid_r <= 1'b0;
            decSecond_r <= 1'b0;
        end else begin
            decWord_r <= progData;
            decValid_r <= 1'b1;
            // mark the following word as operand
            decSecond_r <= decTwoWord;
        end
    end

    // pointer file: decode post-modify and execute writes
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NPTR; i++) begin
                arFile_r[i] <= `WORD_RESET;
            end
            arp_r <= SW'(`ARP_RESET);
            collision_r <= 1'b0;
        end else begin
            if (decIndirect && decMod != pipe_pkg::MOD_NONE) begin
                arFile_r[arp_r] <= ptr_nxt;
            end
            if (exPtrWrite) begin
                arFile_r[exPtrIdx] <= exPtrVal;
            end
            collision_r <= exPtrWrite && decIndirect && decMod != pipe_pkg::MOD_NONE
                && exPtrIdx == arp_r;
            if (decIndirect && decWord_r[`ARP_LOAD_BIT]) begin
                arp_r <= SW'(decWord_r[`ARP_MSB:`ARP_LSB]);
            end
        end
    end

    // decode to read slot, driving the data read address
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdOp_r <= pipe_pkg::OP_NOP;
            rdTgt_r <= 4'h0;
            dataRdAddr_r <= `WORD_RESET;
            dataRdEn_r <= 1'b0;
        end else begin
            rdOp_r <= decOp;
            rdTgt_r <= decWord_r[`TGT_MSB:`TGT_LSB];
            dataRdAddr_r <= curPtr;
            dataRdEn_r <= decIndirect;
        end
    end

    // read to execute slot: latch operand and immediate word
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            exOp_r <= pipe_pkg::OP_NOP;
            exTgt_r <= 4'h0;
            exImm_r <= `WORD_RESET;
            exOperand_r <= `WORD_RESET;
        end else begin
            exOp_r <= rdOp_r;
            exTgt_r <= rdTgt_r;
            // second word sits in decode while its owner is in read
            exImm_r <= decWord_r[DW-1:0];
            exOperand_r <= dataRdEn_r ? dataRdData : `WORD_RESET;
        end
    end

    // execute phase: accumulator
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_r <= `WORD_RESET;
        end else begin
            case (exOp_r)
                pipe_pkg::OP_LDACC_IMM: acc_r <= exImm_r;
                pipe_pkg::OP_LDACC_IND: acc_r <= exOperand_r;
                pipe_pkg::OP_ADD_IND: acc_r <= acc_r + exOperand_r;
                default: acc_r <= acc_r;
            endcase
        end
    end

    // execute phase: index register through mapped store
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            index_r <= `WORD_RESET;
        end else if (exOp_r == pipe_pkg::OP_STORE_MAPPED && exTgt_r == `TGT_INDEX) begin
            index_r <= acc_r;
        end
    end

    assign progAddr = pc_r;
    assign dataRdAddr = dataRdAddr_r;
    assign dataRdEn = dataRdEn_r;
    assign accumulatorReg = acc_r;
    assign auxPointerTwo = arFile_r[2];
    assign ptrCollision = collision_r;
endmodule

// [test/pipe_properties.sv]
// Purpose: port checks of the four-phase pipeline.
// Assumes: pointer target nibble 2 lands in auxPointerTwo.
// Notes: bound to every four_stage_pipeline instance.
`timescale 1ns/10ps
module pipe_properties #(
    parameter int DW = 16,
    parameter int NPTR = 8
) (
    input wire logic sys_clk, // core clock
    input wire logic rst_n, // async reset
    input wire logic fetchStall, // fetch hold
    input wire logic [15:0] progData, // fetched word
    input wire logic [15:0] progAddr, // program counter
    input wire logic [DW-1:0] dataRdData, // read data
    input wire logic [DW-1:0] dataRdAddr, // read address
    input wire logic dataRdEn, // read active
    input wire logic [DW-1:0] accumulatorReg, // accumulator
    input wire logic [DW-1:0] auxPointerTwo, // pointer two
    input wire logic ptrCollision // collision pulse
);
    logic pendTwo;
    logic [3:0] op;
    logic head;
    // a fetched word that opens an instruction
    assign op = progData[15:12];
    assign head = !fetchStall && !pendTwo;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // marks the fetch slot that carries an immediate
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pendTwo <= 1'b0;
        end else if (!fetchStall) begin
            pendTwo <= !pendTwo && (op == pipe_pkg::OP_LDACC_IMM || op == pipe_pkg::OP_LDPTR_IMM);
        end
    end
    property p_pc_step;
        !fetchStall |=> progAddr == $past(progAddr) + 16'h0001;
    endproperty
    a_pc_step: assert property (p_pc_step) else $error("pc did not step");
    property p_pc_hold;
        fetchStall |=> $stable(progAddr);
    endproperty
    a_pc_hold: assert property (p_pc_hold) else $error("pc moved in stall");
    property p_rd_only_ind;
        dataRdEn |-> $past(op, 2) inside {pipe_pkg::OP_LDACC_IND, pipe_pkg::OP_ADD_IND};
    endproperty
    a_rd_only_ind: assert property (p_rd_only_ind) else $error("stray read");
    property p_ldptr;
        head && op == pipe_pkg::OP_LDPTR_IMM && progData[3:0] == 4'h2
            |-> ##4 auxPointerTwo == $past(progData, 3);
    endproperty
    a_ldptr: assert property (p_ldptr) else $error("pointer load wrong");
    property p_ldacc_imm;
        head && op == pipe_pkg::OP_LDACC_IMM |-> ##4 accumulatorReg == $past(progData, 3);
    endproperty
    a_ldacc_imm: assert property (p_ldacc_imm) else $error("acc imm wrong");
    property p_store;
        head && op == pipe_pkg::OP_STORE_MAPPED && progData[3:0] == 4'h2
            |-> ##4 auxPointerTwo == $past(accumulatorReg);
    endproperty
    a_store: assert property (p_store) else $error("mapped store wrong");
    property p_ldacc_ind;
        head && op == pipe_pkg::OP_LDACC_IND
            |-> ##2 dataRdEn ##2 accumulatorReg == $past(dataRdData, 2);
    endproperty
    a_ldacc_ind: assert property (p_ldacc_ind) else $error("acc load wrong");
    property p_add;
        head && op == pipe_pkg::OP_ADD_IND
            |-> ##2 dataRdEn ##2 accumulatorReg == $past(dataRdData, 2) + $past(accumulatorReg);
    endproperty
    a_add: assert property (p_add) else $error("add wrong");
    c_coll: cover property (ptrCollision);
    c_stall: cover property (fetchStall);
    c_read: cover property (dataRdEn);
endmodule
bind four_stage_pipeline pipe_properties #(.DW(DW), .NPTR(NPTR)) u_props (.sys_clk, .rst_n,
    .fetchStall, .progData, .progAddr, .dataRdData, .dataRdAddr, .dataRdEn, .accumulatorReg,
    .auxPointerTwo, .ptrCollision);

// [test/four_stage_pipeline_aux_reg_hazard_test.sv]
// Purpose: runs short programs through the pipeline and checks pointer and acc history.
// Assumes: memories answer combinationally to the registered addresses.
// Notes: stalls are kept away from pending immediates.
`timescale 1ns/10ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_count++; \
    $display("ERROR %0t got %h exp %h", $time, g, e); end end
module four_stage_pipeline_aux_reg_hazard_test;
    logic sys_clk, rst_n, fetchStall, dataRdEn, ptrCollision;
    logic [15:0] progData, progAddr, dataRdData, dataRdAddr, accumulatorReg, auxPointerTwo;
    logic [15:0] progMem [0:31];
    logic [15:0] dataMem [0:255];
    logic [15:0] rdQ[$], ptrQ[$], accQ[$];
    logic [15:0] ptrPrev, accPrev;
    int err_count = 0, total_checks = 0, collCount = 0, cycCount = 0;
    // combinational memories
    assign progData = progMem[progAddr[4:0]];
    assign dataRdData = dataMem[dataRdAddr[7:0]];
    four_stage_pipeline i_dut (.sys_clk, .rst_n, .fetchStall, .progData, .progAddr, .dataRdData,
        .dataRdAddr, .dataRdEn, .accumulatorReg, .auxPointerTwo, .ptrCollision);
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    // records reads, pointer and acc changes, collisions; cuts a hang
    always @(posedge sys_clk) begin
        cycCount++;
        if (cycCount == 1000) begin
            err_count++;
            test_done();
        end
        if (rst_n) begin
            if (dataRdEn === 1'b1) rdQ.push_back(dataRdAddr);
            if (auxPointerTwo !== ptrPrev) ptrQ.push_back(auxPointerTwo);
            if (accumulatorReg !== accPrev) accQ.push_back(accumulatorReg);
            if (ptrCollision === 1'b1) collCount++;
        end
        ptrPrev = auxPointerTwo;
        accPrev = accumulatorReg;
    end
    task automatic test_done;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk_seq(input logic [15:0] got[$], input logic [15:0] exp[$]);
        `CHK(got.size(), exp.size())
        foreach (exp[i]) `CHK(got[i], exp[i])
    endtask
    // resets, loads the program, runs 20 cycles with an optional stall;
    // each program opens with 3140h, an indirect add of zero that selects pointer two
    task automatic run_prog(input logic [15:0] w[$], input int stallAt);
        foreach (progMem[i]) progMem[i] = (i < w.size()) ? w[i] : 16'h0000;
        rst_n <= 1'b0;
        repeat (8) @(posedge sys_clk);
        rdQ.delete();
        ptrQ.delete();
        accQ.delete();
        collCount = 0;
        rst_n <= 1'b1;
        for (int i = 0; i < 20; i++) begin
            @(posedge sys_clk);
            fetchStall <= (i == stallAt);
        end
        // let the last edge settle before the caller looks
        @(negedge sys_clk);
    endtask
    task automatic t_collide;
        run_prog({16'h3140, 16'h4142, 16'h0067, 16'h1000, 16'h0064, 16'h5002, 16'h2020,
            16'h3020}, -1);
        chk_seq(rdQ, {16'h0000, 16'h0067, 16'h0066});
        chk_seq(ptrQ, {16'h0067, 16'h0066, 16'h0064});
        chk_seq(accQ, {16'h0064, 16'h0050, 16'h0090});
        `CHK(collCount, 1)
        `CHK(progAddr, 16'h0014)
    endtask
    // one nop between the indirect ops
    task automatic t_one_nop;
        run_prog({16'h3140, 16'h4142, 16'h0067, 16'h1000, 16'h0064, 16'h5002, 16'h2020,
            16'h0000, 16'h3020}, -1);
        chk_seq(rdQ, {16'h0000, 16'h0067, 16'h0064});
        chk_seq(ptrQ, {16'h0067, 16'h0066, 16'h0064, 16'h0063});
        chk_seq(accQ, {16'h0064, 16'h0050, 16'h0070});
        `CHK(collCount, 0)
    endtask
    // stall plus a nop carrying a modify field
    task automatic t_stall_nops;
        run_prog({16'h3140, 16'h4142, 16'h0067, 16'h1000, 16'h0064, 16'h5002, 16'h0020,
            16'h0000, 16'h2020, 16'h3020}, 6);
        chk_seq(rdQ, {16'h0000, 16'h0064, 16'h0063});
        chk_seq(ptrQ, {16'h0067, 16'h0064, 16'h0063, 16'h0062});
        chk_seq(accQ, {16'h0064, 16'h0020, 16'h0030});
        `CHK(progAddr, 16'h0013)
    endtask
    // index register loaded by mapped store, used three slots later after two nops, then a +1 step
    task automatic t_index;
        run_prog({16'h3140, 16'h4142, 16'h0067, 16'h1000, 16'h0002, 16'h5008, 16'h0000,
            16'h0000, 16'h2030, 16'h3010}, -1);
        chk_seq(rdQ, {16'h0000, 16'h0067, 16'h0069});
        chk_seq(ptrQ, {16'h0067, 16'h0069, 16'h006a});
        chk_seq(accQ, {16'h0002, 16'h0050});
        `CHK(collCount, 0)
    endtask
    initial begin
        rst_n = 1'b0;
        fetchStall = 1'b0;
        foreach (dataMem[i]) dataMem[i] = 16'h0000;
        for (int i = 3; i < 8; i++) dataMem[8'h60 + i] = 16'(16 * (i - 2));
        t_collide();
        t_one_nop();
        t_stall_nops();
        t_index();
        test_done();
    end
endmodule
